/* include/secr_pkg.sv */
package secr_pkg;
   // register offsets (byte addresses on the register port)
   localparam logic [7:0] ADDR_ENABLE = 8'h80;
   localparam logic [7:0] ADDR_IRQ = 8'h81;
   localparam logic [7:0] ADDR_LIM_LO_L = 8'h8A;
   localparam logic [7:0] ADDR_LIM_LO_H = 8'h8B;
   localparam logic [7:0] ADDR_LIM_HI_L = 8'h8C;
   localparam logic [7:0] ADDR_LIM_HI_H = 8'h8D;
   localparam logic [7:0] ADDR_FILTER = 8'h8E;
   // reset values
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_IRQ = 8'h00;
   localparam logic [7:0] RST_LIM_LO = 8'h00;
   localparam logic [7:0] RST_LIM_HI = 8'hFF;
   localparam logic [7:0] RST_FILTER = 8'h02;
   // enable register fields
   localparam int EN_SLEEP_BIT = 7;
   localparam int EN_RETAIN_BIT = 6;
   localparam int EN_CAPDBL_BIT = 5;
   localparam int EN_LEDDIV_BIT = 4;
   localparam int EN_WAIT_BIT = 3;
   localparam int EN_PROX_BIT = 2;
   localparam int EN_LIGHT_BIT = 1;
   localparam int EN_OSC_BIT = 0;
   // irq register fields
   localparam int IRQ_ABOVE_BIT = 5;
   localparam int IRQ_BELOW_BIT = 4;
   localparam int IRQ_VALID_BIT = 3;
   localparam int IRQ_SEL_BIT = 2;
   localparam int IRQ_PROX_EN_BIT = 1;
   localparam int IRQ_VALID_EN_BIT = 0;
   localparam logic [7:0] IRQ_WRITE_MASK = 8'h07;
   localparam logic [7:0] FILTER_MASK = 8'h0F;
   // consecutive count code table
   localparam logic [5:0] CNT_CODE1 = 6'h01;
   localparam logic [5:0] CNT_CODE2 = 6'h02;
   localparam logic [5:0] CNT_CODE3 = 6'h03;
   localparam logic [5:0] CNT_CODE4 = 6'h05;
   localparam logic [5:0] CNT_CODE5 = 6'h0A;
   localparam logic [5:0] CNT_CODEF = 6'h3C;
endpackage : secr_pkg

/* src/secr_persist.sv */
`timescale 1ns/100ps
// counts consecutive out-of-window samples from the selected proximity or clear channel
module secr_persist
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sample_stb,
   input wire logic [15:0] i_sample,
   input wire logic [15:0] i_low_limit,
   input wire logic [15:0] i_high_limit,
   input wire logic [3:0] i_code,
   output logic o_fire_above,
   output logic o_fire_below
);
   logic [5:0] run_reg;
   logic [5:0] run_next;
   logic [5:0] need;
   logic is_below;
   logic is_above;
   logic hit;

   // window compare on full 16-bit limits
   assign is_below = i_sample < i_low_limit;
   assign is_above = i_sample > i_high_limit;

   // unlisted codes fall back to a single sample
   assign need = (i_code == 4'h2) ? secr_pkg::CNT_CODE2 :
                 (i_code == 4'h3) ? secr_pkg::CNT_CODE3 :
                 (i_code == 4'h4) ? secr_pkg::CNT_CODE4 :
                 (i_code == 4'h5) ? secr_pkg::CNT_CODE5 :
                 (i_code == 4'hF) ? secr_pkg::CNT_CODEF : secr_pkg::CNT_CODE1;

   // saturate at the target so a long excursion fires once per run
   assign run_next = !(is_below || is_above) ? 6'h00 :
                     (run_reg == need) ? run_reg : 6'(run_reg + 6'h01);
   assign hit = i_sample_stb && (is_below || is_above) && (run_next == need)
                && (run_reg != need);

   // run length counter
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         run_reg <= 6'h00;
      else if (i_sample_stb)
         run_reg <= run_next;
   end

   // sample-level retention handled downstream; one pulse per qualifying run
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_fire_above <= 1'b0;
         o_fire_below <= 1'b0;
      end
      else
      begin
         o_fire_above <= hit && is_above;
         o_fire_below <= hit && is_below;
      end
   end
endmodule : secr_persist

/* src/secr_sync.sv */
`timescale 1ns/100ps
// two flip-flop level synchroniser
module secr_sync
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_async,
   output logic o_sync
);
   logic meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         meta_reg <= 1'b0;
         o_sync <= 1'b0;
      end
      else
      begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end
endmodule : secr_sync

/* src/secr_top.sv */
`timescale 1ns/100ps
module secr_top
(
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic I_REG_ACTIVE,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [7:0] I_REG_ADDR,
   input wire logic [7:0] I_REG_WDATA,
   output logic [7:0] O_REG_RDATA,
   input wire logic I_PROX_STB,
   input wire logic [15:0] I_PROX_SAMPLE,
   input wire logic I_CLEAR_STB,
   input wire logic [15:0] I_CLEAR_SAMPLE,
   input wire logic I_LIGHT_DONE,
   output logic O_OSC_RUN,
   output logic O_WAIT_EN,
   output logic O_PROX_EN,
   output logic O_LIGHT_EN,
   output logic O_PROX_CAP_DOUBLE,
   output logic O_LED_CURRENT_DIVIDER,
   output logic O_INT_N_O,
   output logic O_INT_N_OE
);
   logic [7:0] enable_reg;
   logic [7:0] irq_reg;
   logic [7:0] lim_lo_l_reg;
   logic [7:0] lim_lo_h_reg;
   logic [7:0] lim_hi_l_reg;
   logic [7:0] lim_hi_h_reg;
   logic [7:0] filter_reg;
   logic sleep_reg;
   logic pulse_reg;
   logic active_sync;
   logic wr_enable;
   logic wr_irq;
   logic wr_lo_l;
   logic wr_lo_h;
   logic wr_hi_l;
   logic wr_hi_h;
   logic wr_filter;
   logic rd_irq;
   logic [15:0] low_limit;
   logic [15:0] high_limit;
   logic cmp_stb;
   logic [15:0] cmp_sample;
   logic fire_above;
   logic fire_below;
   logic valid_set;
   logic prox_irq_on;
   logic valid_irq_on;
   logic irq_level;
   logic irq_event;
   logic irq_pending;
   logic [7:0] rdata_next;
   logic sleep_entry;
   logic osc_want;

   // register access strobe may come from the serial front end's own clock
   secr_sync u_active_sync
   (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RESET),
      .i_async(I_REG_ACTIVE),
      .o_sync(active_sync)
   );

   // write decode: at most one byte strobe, none for unmapped addresses
   always_comb
   begin
      wr_enable = 1'b0;
      wr_irq = 1'b0;
      wr_lo_l = 1'b0;
      wr_lo_h = 1'b0;
      wr_hi_l = 1'b0;
      wr_hi_h = 1'b0;
      wr_filter = 1'b0;
      if (I_REG_WR)
      begin
         if (I_REG_ADDR == secr_pkg::ADDR_ENABLE)
            wr_enable = 1'b1;
         else if (I_REG_ADDR == secr_pkg::ADDR_IRQ)
            wr_irq = 1'b1;
         else if (I_REG_ADDR == secr_pkg::ADDR_LIM_LO_L)
            wr_lo_l = 1'b1;
         else if (I_REG_ADDR == secr_pkg::ADDR_LIM_LO_H)
            wr_lo_h = 1'b1;
         else if (I_REG_ADDR == secr_pkg::ADDR_LIM_HI_L)
            wr_hi_l = 1'b1;
         else if (I_REG_ADDR == secr_pkg::ADDR_LIM_HI_H)
            wr_hi_h = 1'b1;
         else if (I_REG_ADDR == secr_pkg::ADDR_FILTER)
            wr_filter = 1'b1;
      end
   end

   // a read of the flag register clears the latched flags
   assign rd_irq = I_REG_RD && (I_REG_ADDR == secr_pkg::ADDR_IRQ);

   // limits assembled from byte pairs
   assign low_limit = {lim_lo_h_reg, lim_lo_l_reg};
   assign high_limit = {lim_hi_h_reg, lim_hi_l_reg};

   // threshold compare source select
   assign cmp_stb = irq_reg[secr_pkg::IRQ_SEL_BIT] ? I_CLEAR_STB : I_PROX_STB;
   assign cmp_sample = irq_reg[secr_pkg::IRQ_SEL_BIT] ? I_CLEAR_SAMPLE
                                                      : I_PROX_SAMPLE;

   secr_persist u_persist
   (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RESET),
      .i_sample_stb(cmp_stb),
      .i_sample(cmp_sample),
      .i_low_limit(low_limit),
      .i_high_limit(high_limit),
      .i_code(filter_reg[3:0]),
      .o_fire_above(fire_above),
      .o_fire_below(fire_below)
   );

   assign valid_set = I_LIGHT_DONE && !sleep_reg;

   // enable register, written whole
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
         enable_reg <= secr_pkg::RST_ENABLE;
      else if (wr_enable)
         enable_reg <= I_REG_WDATA;
   end

   // irq register: flags set by hardware win over read-clear
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
         irq_reg <= secr_pkg::RST_IRQ;
      else
      begin
         if (wr_irq)
            irq_reg[2:0] <= I_REG_WDATA[2:0];
         if (fire_above)
            irq_reg[secr_pkg::IRQ_ABOVE_BIT] <= 1'b1;
         else if (rd_irq)
            irq_reg[secr_pkg::IRQ_ABOVE_BIT] <= 1'b0;
         if (fire_below)
            irq_reg[secr_pkg::IRQ_BELOW_BIT] <= 1'b1;
         else if (rd_irq)
            irq_reg[secr_pkg::IRQ_BELOW_BIT] <= 1'b0;
         if (valid_set)
            irq_reg[secr_pkg::IRQ_VALID_BIT] <= 1'b1;
         else if (rd_irq)
            irq_reg[secr_pkg::IRQ_VALID_BIT] <= 1'b0;
      end
   end

   // threshold byte registers
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
      begin
         lim_lo_l_reg <= secr_pkg::RST_LIM_LO;
         lim_lo_h_reg <= secr_pkg::RST_LIM_LO;
         lim_hi_l_reg <= secr_pkg::RST_LIM_HI;
         lim_hi_h_reg <= secr_pkg::RST_LIM_HI;
      end
      else
      begin
         if (wr_lo_l)
            lim_lo_l_reg <= I_REG_WDATA;
         if (wr_lo_h)
            lim_lo_h_reg <= I_REG_WDATA;
         if (wr_hi_l)
            lim_hi_l_reg <= I_REG_WDATA;
         if (wr_hi_h)
            lim_hi_h_reg <= I_REG_WDATA;
      end
   end

   // filter register, low nibble only
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
         filter_reg <= secr_pkg::RST_FILTER;
      else if (wr_filter)
         filter_reg <= I_REG_WDATA & secr_pkg::FILTER_MASK;
   end

   // interrupt gating per source
   assign prox_irq_on = irq_reg[secr_pkg::IRQ_PROX_EN_BIT]
                        && (irq_reg[secr_pkg::IRQ_ABOVE_BIT]
                        || irq_reg[secr_pkg::IRQ_BELOW_BIT]);
   assign valid_irq_on = irq_reg[secr_pkg::IRQ_VALID_EN_BIT]
                         && irq_reg[secr_pkg::IRQ_VALID_BIT];
   assign irq_level = prox_irq_on || valid_irq_on;
   assign irq_event = (irq_reg[secr_pkg::IRQ_PROX_EN_BIT] && (fire_above || fire_below))
                      || (irq_reg[secr_pkg::IRQ_VALID_EN_BIT] && valid_set);
   assign irq_pending = irq_level || pulse_reg;

   // pulse mode gives one cycle of pin drive per enabled threshold fire or valid event only
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
         pulse_reg <= 1'b0;
      else
         pulse_reg <= irq_event && enable_reg[secr_pkg::EN_RETAIN_BIT];
   end

   // sleep is entered only when a light cycle closes with an irq already out
   assign sleep_entry = I_LIGHT_DONE && enable_reg[secr_pkg::EN_SLEEP_BIT]
                        && irq_pending;

   // an access overrides power bit and sleep, so the host can always reach the bank
   assign osc_want = (enable_reg[secr_pkg::EN_OSC_BIT] && !sleep_reg)
                     || active_sync;

   // sleep latches at the end of a light cycle while an irq is out
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
         sleep_reg <= 1'b0;
      else if (wr_enable)
         sleep_reg <= 1'b0;
      else if (sleep_entry)
         sleep_reg <= 1'b1;
   end

   // function enables; sleep gates the oscillator but an access still wakes it
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
      begin
         O_OSC_RUN <= 1'b0;
         O_WAIT_EN <= 1'b0;
         O_PROX_EN <= 1'b0;
         O_LIGHT_EN <= 1'b0;
         O_PROX_CAP_DOUBLE <= 1'b0;
         O_LED_CURRENT_DIVIDER <= 1'b0;
      end
      else
      begin
         O_OSC_RUN <= osc_want;
         O_WAIT_EN <= enable_reg[secr_pkg::EN_WAIT_BIT];
         O_PROX_EN <= enable_reg[secr_pkg::EN_PROX_BIT];
         O_LIGHT_EN <= enable_reg[secr_pkg::EN_LIGHT_BIT];
         O_PROX_CAP_DOUBLE <= enable_reg[secr_pkg::EN_CAPDBL_BIT];
         O_LED_CURRENT_DIVIDER <= enable_reg[secr_pkg::EN_LEDDIV_BIT];
      end
   end

   // open-drain pin: only ever driven low
   assign O_INT_N_O = 1'b0;
   assign O_INT_N_OE = enable_reg[secr_pkg::EN_RETAIN_BIT] ? pulse_reg
                                                           : irq_level;

   // read mux; unmapped addresses read zero so a probe never sees stale data
   always_comb
   begin
      rdata_next = 8'h00;
      if (I_REG_ADDR == secr_pkg::ADDR_ENABLE)
         rdata_next = enable_reg;
      else if (I_REG_ADDR == secr_pkg::ADDR_IRQ)
         rdata_next = irq_reg;
      else if (I_REG_ADDR == secr_pkg::ADDR_LIM_LO_L)
         rdata_next = lim_lo_l_reg;
      else if (I_REG_ADDR == secr_pkg::ADDR_LIM_LO_H)
         rdata_next = lim_lo_h_reg;
      else if (I_REG_ADDR == secr_pkg::ADDR_LIM_HI_L)
         rdata_next = lim_hi_l_reg;
      else if (I_REG_ADDR == secr_pkg::ADDR_LIM_HI_H)
         rdata_next = lim_hi_h_reg;
      else if (I_REG_ADDR == secr_pkg::ADDR_FILTER)
         rdata_next = filter_reg;
   end

   // read data registered on the read strobe
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RESET)
         O_REG_RDATA <= 8'h00;
      else if (I_REG_RD)
         O_REG_RDATA <= rdata_next;
   end
endmodule : secr_top

/* dv/secr_top_chk.sv */
`timescale 1ns/100ps
// port-level checks of the enable and interrupt bank
module secr_top_chk
(
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic I_REG_ACTIVE,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [7:0] I_REG_ADDR,
   input wire logic [7:0] I_REG_WDATA,
   input wire logic [7:0] O_REG_RDATA,
   input wire logic I_PROX_STB,
   input wire logic I_CLEAR_STB,
   input wire logic I_LIGHT_DONE,
   input wire logic O_OSC_RUN,
   input wire logic O_WAIT_EN,
   input wire logic O_PROX_EN,
   input wire logic O_LIGHT_EN,
   input wire logic O_PROX_CAP_DOUBLE,
   input wire logic O_LED_CURRENT_DIVIDER,
   input wire logic O_INT_N_OE
);
   logic [3:0] shd_reg;
   logic [3:0] shd_next;
   wire logic rd_irq = I_REG_RD && (I_REG_ADDR == secr_pkg::ADDR_IRQ);
   wire logic wr_en = I_REG_WR && (I_REG_ADDR == secr_pkg::ADDR_ENABLE);
   wire logic wr_irq = I_REG_WR && (I_REG_ADDR == secr_pkg::ADDR_IRQ);
   // shadow of retention, power and irq enables, so no peek inside is needed
   assign shd_next[3:2] = wr_en ? {I_REG_WDATA[6], I_REG_WDATA[0]} : shd_reg[3:2];
   assign shd_next[1:0] = wr_irq ? I_REG_WDATA[1:0] : shd_reg[1:0];
   always_ff @(posedge I_CLK_SYS)
   begin
      shd_reg <= I_RESET ? 4'h0 : shd_next;
   end
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RESET);
   // flags set up to two edges late would survive the read
   sequence s_quiet_read;
      rd_irq && !I_LIGHT_DONE && !$past(I_LIGHT_DONE) && !$past(I_LIGHT_DONE, 2)
         && !$past(I_PROX_STB) && !$past(I_CLEAR_STB);
   endsequence
   sequence s_act_held;
      I_REG_ACTIVE [*4];
   endsequence
   property p_en_copy;
      logic [7:0] d;
      (wr_en, d = I_REG_WDATA) |-> ##2 ({O_PROX_CAP_DOUBLE, O_LED_CURRENT_DIVIDER,
         O_WAIT_EN, O_PROX_EN, O_LIGHT_EN} == d[5:1]);
   endproperty
   a_en_copy: assert property (p_en_copy) else $error("enable copy");
   property p_osc_act;
      s_act_held |=> O_OSC_RUN;
   endproperty
   a_osc_act: assert property (p_osc_act) else $error("osc off in access");
   property p_osc_cause;
      $rose(O_OSC_RUN) |-> ($past(shd_reg[2]) || $past(I_REG_ACTIVE, 2)
         || $past(I_REG_ACTIVE, 3) || $past(I_REG_ACTIVE, 4));
   endproperty
   a_osc_cause: assert property (p_osc_cause) else $error("osc rose alone");
   property p_read_clr;
      s_quiet_read |=> !O_INT_N_OE;
   endproperty
   a_read_clr: assert property (p_read_clr) else $error("irq kept after read");
   property p_gate;
      (shd_reg[1:0] == 2'b00) |-> !O_INT_N_OE;
   endproperty
   a_gate: assert property (p_gate) else $error("irq while disabled");
   property p_hold;
      (O_INT_N_OE && !shd_reg[3] && !I_REG_WR && !rd_irq) |=> O_INT_N_OE;
   endproperty
   a_hold: assert property (p_hold) else $error("level irq dropped");
   property p_pulse;
      (O_INT_N_OE && shd_reg[3] && !shd_reg[0] && !$past(I_PROX_STB)
         && !$past(I_CLEAR_STB)) |=> !O_INT_N_OE;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse too long");
   property p_filter;
      (I_REG_RD && (I_REG_ADDR == secr_pkg::ADDR_FILTER)) |=> (O_REG_RDATA[7:4] == 4'h0);
   endproperty
   a_filter: assert property (p_filter) else $error("filter upper bits");
endmodule : secr_top_chk
bind secr_top secr_top_chk u_chk (.*);

/* dv/secr_host.sv */
`timescale 1ns/100ps
// host side of the serial register link, one access at a time
module secr_host
(
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output logic o_active = 1'b0,
   output logic o_wr = 1'b0,
   output logic o_rd = 1'b0,
   output logic [7:0] o_addr = 8'h00,
   output logic [7:0] o_wdata = 8'h00
);
   // address and data turn to garbage once released, never holding stale values
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
   begin
      @(posedge i_clk);
      o_active <= 1'b1;
      repeat (2) @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= w;
      o_rd <= !w;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
      @(posedge i_clk);
      q = i_rdata;
      o_active <= 1'b0;
   end
   endtask : xfer
endmodule : secr_host

/* dv/sensor_enable_interrupt_ctrl_test.sv */
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin $display("[FAIL] %s exp %h got %h", n, e, a); num_errors++; end end
module sensor_enable_interrupt_ctrl_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pstb = 1'b0;
   logic cstb = 1'b0;
   logic done = 1'b0;
   logic [15:0] psmp = 16'h0000;
   logic [15:0] csmp = 16'h0000;
   logic act, wr, rd, osc, wen, pen, len, cap, led, int_o, int_oe;
   logic [7:0] addr, wdata, rdata;
   int num_errors = 0;
   int compares = 0;
   secr_host host (.i_clk(clk), .i_rdata(rdata), .o_active(act), .o_wr(wr), .o_rd(rd),
      .o_addr(addr), .o_wdata(wdata));
   secr_top dut (.I_CLK_SYS(clk), .I_RESET(rst), .I_REG_ACTIVE(act), .I_REG_WR(wr),
      .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
      .I_PROX_STB(pstb), .I_PROX_SAMPLE(psmp), .I_CLEAR_STB(cstb), .I_CLEAR_SAMPLE(csmp),
      .I_LIGHT_DONE(done), .O_OSC_RUN(osc), .O_WAIT_EN(wen), .O_PROX_EN(pen),
      .O_LIGHT_EN(len), .O_PROX_CAP_DOUBLE(cap), .O_LED_CURRENT_DIVIDER(led),
      .O_INT_N_O(int_o), .O_INT_N_OE(int_oe));
   // free-running system clock
   initial
   begin
      forever #5 clk = ~clk;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
   begin
      host.xfer(1'b1, a, d, q);
   end
   endtask : wr_reg
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
   begin
      host.xfer(1'b0, a, 8'h00, q);
      `CHK("rdata", e, q)
   end
   endtask : rchk
   // one sample on the chosen channel, then a quiet cycle
   task automatic smp(input logic src, input logic [15:0] v);
   begin
      @(posedge clk);
      psmp <= v;
      csmp <= v;
      pstb <= !src;
      cstb <= src;
      @(posedge clk);
      pstb <= 1'b0;
      cstb <= 1'b0;
   end
   endtask : smp
   // in-window sample first, since a saturated run would never fire again
   task automatic run(input int n, input logic [15:0] v, input logic f);
   begin
      smp(1'b0, 16'h0800);
      repeat (n - 1) smp(1'b0, v);
      repeat (3) @(posedge clk);
      `CHK("early", 1'b0, int_oe)
      smp(1'b0, v);
      @(posedge clk); // a pulse-mode drive stands only in this one cycle
      #1 `CHK("fire", f, int_oe)
   end
   endtask : run
   task automatic t_regs();
      logic [7:0] ra [8] = '{8'h80, 8'h81, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h90};
      logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h02, 8'h00};
   begin
      for (int i = 0; i < 8; i++)
         rchk(ra[i], rv[i]);
      wr_reg(8'h80, 8'h3E);
      repeat (2) @(posedge clk);
      `CHK("enables", 5'h1F, {cap, led, wen, pen, len})
      wr_reg(8'h80, 8'h01);
      repeat (2) @(posedge clk);
      `CHK("osc on", 1'b1, osc)
      `CHK("enables off", 5'h00, {cap, led, wen, pen, len})
      wr_reg(8'h80, 8'h00);
      repeat (5) @(posedge clk);
      `CHK("osc off", 1'b0, osc)
      $display("done registers");
   end
   endtask : t_regs
   task automatic t_persist();
      logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hF};
      int cnt [6] = '{1, 2, 3, 5, 10, 60};
   begin
      wr_reg(8'h8B, 8'h01);
      wr_reg(8'h8D, 8'h10);
      wr_reg(8'h8C, 8'h00);
      rchk(8'h8D, 8'h10);
      wr_reg(8'h81, 8'h02);
      for (int i = 0; i < 6; i++)
      begin
         wr_reg(8'h8E, {4'h0, codes[i]});
         run(cnt[i], 16'h2000, 1'b1);
         rchk(8'h81, 8'h22);
         `CHK("cleared", 1'b0, int_oe)
      end
      wr_reg(8'h8E, 8'h03);
      run(3, 16'h0050, 1'b1);
      rchk(8'h81, 8'h12);
      smp(1'b0, 16'h2000);
      smp(1'b0, 16'h2000);
      run(3, 16'h2000, 1'b1);
      rchk(8'h81, 8'h22);
      $display("done persistence");
   end
   endtask : t_persist
   task automatic t_modes();
   begin
      wr_reg(8'h80, 8'h40);
      run(3, 16'h2000, 1'b1);
      @(posedge clk);
      #1 `CHK("pulse end", 1'b0, int_oe)
      rchk(8'h81, 8'h22);
      wr_reg(8'h80, 8'h00);
      wr_reg(8'h81, 8'h06);
      smp(1'b1, 16'h0800);
      smp(1'b0, 16'h2000);
      smp(1'b0, 16'h2000);
      smp(1'b0, 16'h2000);
      repeat (3) @(posedge clk);
      `CHK("prox ignored", 1'b0, int_oe)
      repeat (3) smp(1'b1, 16'h2000);
      repeat (2) @(posedge clk);
      #1 `CHK("clear fires", 1'b1, int_oe)
      rchk(8'h81, 8'h26);
      wr_reg(8'h81, 8'h00);
      run(3, 16'h2000, 1'b0);
      `CHK("masked", 1'b0, int_oe)
      wr_reg(8'h81, 8'h02);
      `CHK("unmasked", 1'b1, int_oe)
      rchk(8'h81, 8'h22);
      $display("done modes");
   end
   endtask : t_modes
   task automatic t_sleep();
   begin
      wr_reg(8'h81, 8'h01);
      wr_reg(8'h80, 8'h81);
      repeat (2)
      begin
         @(posedge clk);
         done <= 1'b1;
         @(posedge clk);
         done <= 1'b0;
      end
      repeat (4) @(posedge clk);
      `CHK("valid irq", 1'b1, int_oe)
      `CHK("asleep", 1'b0, osc)
      rchk(8'h81, 8'h09);
      repeat (5) @(posedge clk);
      `CHK("still asleep", 1'b0, osc)
      wr_reg(8'h80, 8'h01);
      repeat (5) @(posedge clk);
      `CHK("woken", 1'b1, osc)
      `CHK("pin low level", 1'b0, int_o)
      $display("done sleep");
   end
   endtask : t_sleep
   task automatic close_out();
   begin
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask : close_out
   // main sequence after two cycles of reset
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_persist();
      t_modes();
      t_sleep();
      close_out();
   end
   // a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      close_out();
   end
endmodule : sensor_enable_interrupt_ctrl_test
